//--- core/ext_memory_block_copy.v
// Block-copy sequencer between central memory and the large core extension.
// Assumes operating registers and the issue pipeline sit outside, on the same clk.
// How it works
// R1: Immediate count comes from low 18 bits of the two-parcel instruction.
// R2: Opcode 011 copies extension to central; 012 central to extension, consecutive words.
// R3: Extension start is low 21 bits of address operand plus 22-bit reference base.
// R4: Range checks use low 22 bits of extension field length.
// R5: Central start address comes from the central address register.
// R6: Count is index plus immediate in 18-bit one's complement, taken positive.
// R7: Block count is low 10 bits of count; truncation alone flags nothing.
// R8: Overrun check uses full 18-bit count and raises block range error.
// R9: Zero count makes the instruction a pass, moving no words.
// R10: Wait for earlier instructions to finish, then hold issue until nearly done.
// R11: Extension-to-central copy halts all activity except I/O word requests.
// R12: Central-to-extension copy halts all except I/O or peripheral requests.
// R13: Up to one 60-bit word per clock in either direction.
// R14: I/O request pauses stream one clock, inserts its address, stream resumes after. Here block grants pause two clocks: the I/O slot plus a gap.
// R15: Central, extension and index registers are left unchanged.
// R16: Exit bit 86 set continues next parcel; clear skips to next word.
// R17: Range error stops further transfers and reports to exception logic.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "blk_copy_regs.vh"
module ext_memory_block_copy
#(
	parameter NEAR_DONE = 2
)
(
	input wire clk,
	input wire sys_rst,
	input wire instr_valid,
	input wire [29:0] instr_word,
	input wire prior_done,
	input wire [`CM_ADDR_W-1:0] central_addr_reg,
	input wire [59:0] ext_addr_operand_reg,
	input wire [17:0] count_index_reg,
	input wire [`EXT_BASE_W-1:0] ext_reference_base,
	input wire [`EXT_BASE_W-1:0] ext_field_length,
	input wire [`SCW_W-1:0] system_control_word,
	input wire io_req,
	input wire [`CM_ADDR_W-1:0] io_addr,
	input wire peripheral_subsystem_requests,
	input wire bank_busy,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_r,
	output wire busy,
	output wire hold_issue,
	output wire halt_other,
	output reg instr_done_r,
	output reg skip_to_next_word_r,
	output reg range_err_r,
	output wire cm_req_valid,
	output wire [`CM_ADDR_W-1:0] cm_req_addr,
	output wire cm_req_is_io,
	output wire cm_req_write,
	output reg ext_req_valid_r,
	output reg [`EXT_ADDR_W-1:0] ext_req_addr_r,
	output reg ext_req_write_r,
	output wire irq
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam S_IDLE = 2'h0;
	localparam S_DRAIN = 2'h1;
	localparam S_XFER = 2'h2;
	localparam S_EXIT = 2'h3;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg dir_r;
	reg [`BLK_W-1:0] left_r;
	reg [`CM_ADDR_W-1:0] cm_ptr_r;
	reg [`EXT_ADDR_W-1:0] ext_ptr_r;
	reg [17:0] count_r;
	reg [`ST_W-1:0] status_r;
	reg [`ST_W-1:0] mask_r;
	reg [`BLK_W-1:0] imm_dummy_r;
	wire [8:0] opc;
	wire is_copy;
	wire [17:0] imm;
	wire [17:0] count;
	wire [`EXT_ADDR_W-1:0] ext_start;
	wire over;
	wire grant;
	wire [`ST_W-1:0] ev;
	wire [`ST_W-1:0] clr;

	assign opc = instr_word[`OPC_HI:`OPC_LO];
	assign is_copy = (opc == `OPC_EXT_TO_CM) || (opc == `OPC_CM_TO_EXT); // R2
	assign imm = instr_word[`IMM_W-1:0]; // R1

	// ----------------------------------------
	// Count and address forming
	// ----------------------------------------
	ones_add18 u_add
	(
		.a(count_index_reg),
		.b(imm),
		.sum(count)
	); // R6

	// Operand registers are only read, never written here
	assign ext_start = {1'b0, ext_addr_operand_reg[`EXT_OFS_W-1:0]} + ext_reference_base; // R3 R15

	// Full 18-bit count checked, not the truncated one; 23-bit sum avoids wrap
	assign over = ({1'b0, ext_addr_operand_reg[`EXT_OFS_W-1:0]} + {5'h00, count_r})
		> {1'b0, ext_field_length}; // R4 R8

	function [`BLK_W-1:0] trunc_cnt;
		input [17:0] c;
		begin
			trunc_cnt = c[`BLK_W-1:0];
		end
	endfunction

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE:
				if (instr_valid && is_copy)
					state_nxt = S_DRAIN;
			S_DRAIN:
				if (prior_done) // R10
					state_nxt = (over || trunc_cnt(count_r) == 10'h000) ? S_EXIT : S_XFER; // R9 R17
			S_XFER:
				if (grant && left_r == 10'h001)
					state_nxt = S_EXIT;
			S_EXIT:
				state_nxt = S_IDLE;
			default:
				state_nxt = S_IDLE;
		endcase
	end

	io_slot_arbiter u_arb
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.io_req(io_req),
		.io_addr(io_addr),
		.bank_busy(bank_busy),
		.blk_want(state_r == S_XFER),
		.blk_addr(cm_ptr_r),
		.blk_grant(grant),
		.req_valid_r(cm_req_valid),
		.req_addr_r(cm_req_addr),
		.req_is_io_r(cm_req_is_io)
	); // R13 R14

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r <= S_IDLE;
			dir_r <= 1'b0;
			left_r <= 10'h000;
			cm_ptr_r <= 18'h00000;
			ext_ptr_r <= 22'h000000;
			count_r <= 18'h00000;
			instr_done_r <= 1'b0;
			skip_to_next_word_r <= 1'b0;
			range_err_r <= 1'b0;
			ext_req_valid_r <= 1'b0;
			ext_req_addr_r <= 22'h000000;
			ext_req_write_r <= 1'b0;
			imm_dummy_r <= 10'h000;
		end
		else
		begin
			state_r <= state_nxt;
			instr_done_r <= 1'b0;
			range_err_r <= 1'b0;
			ext_req_valid_r <= 1'b0;
			if (state_r == S_IDLE && instr_valid && is_copy)
			begin
				dir_r <= (opc == `OPC_CM_TO_EXT); // R2
				count_r <= count;
				cm_ptr_r <= central_addr_reg; // R5
				ext_ptr_r <= ext_start; // R3
			end
			if (state_r == S_DRAIN && prior_done)
			begin
				left_r <= trunc_cnt(count_r); // R7
				range_err_r <= over; // R8 R17
			end
			if (state_r == S_XFER && grant)
			begin
				// One word per clock, consecutive addresses on both sides
				cm_ptr_r <= cm_ptr_r + 18'h00001; // R13
				ext_ptr_r <= ext_ptr_r + 22'h000001;
				left_r <= left_r - 10'h001;
				ext_req_valid_r <= 1'b1;
				ext_req_addr_r <= ext_ptr_r;
				ext_req_write_r <= dir_r;
			end
			if (state_r == S_EXIT)
			begin
				instr_done_r <= 1'b1;
				skip_to_next_word_r <= ~system_control_word[`EXIT_CTRL_BIT]; // R16
			end
			imm_dummy_r <= 10'h000;
		end
	end

	assign cm_req_write = ~dir_r;
	assign busy = (state_r != S_IDLE);
	// Issue released a few words before the end so the next instruction can decode early
	assign hold_issue = (state_r == S_DRAIN) ||
		(state_r == S_XFER && left_r > NEAR_DONE[`BLK_W-1:0]); // R10
	// Direction decides which outside requesters may still run
	assign halt_other = (state_r == S_XFER) &&
		(dir_r ? ~peripheral_subsystem_requests : 1'b1); // R11 R12

	// ----------------------------------------
	// Status, mask, interrupt
	// ----------------------------------------
	assign ev = {state_r == S_DRAIN && prior_done && !over && trunc_cnt(count_r) == 10'h000,
		range_err_r, instr_done_r};
	assign clr = (reg_wr && reg_addr == `REG_STATUS) ? reg_wdata[`ST_W-1:0] : 3'h0;

	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			status_r <= 3'h0;
			mask_r <= 3'h0;
			reg_rdata_r <= 32'h00000000;
		end
		else
		begin
			// Set wins over clear so no event is lost
			status_r <= (status_r & ~clr) | ev;
			if (reg_wr && reg_addr == `REG_MASK)
				mask_r <= reg_wdata[`ST_W-1:0];
			reg_rdata_r <= 32'h00000000;
			if (reg_rd)
			begin
				case (reg_addr)
					`REG_STATUS: reg_rdata_r <= {29'h00000000, status_r};
					`REG_MASK: reg_rdata_r <= {29'h00000000, mask_r};
					`REG_INFO: reg_rdata_r <= {state_r, left_r, 2'h0, count_r};
					default: reg_rdata_r <= 32'h00000000;
				endcase
			end
		end
	end

	assign irq = |(status_r & mask_r);
endmodule

//--- core/io_slot_arbiter.v
// Merges I/O word requests into the memory request stream during a block copy.
// Assumes io_req is a pulse from logic in the clk domain.
`timescale 1ns/1ns
`include "blk_copy_regs.vh"
module io_slot_arbiter
(
	input wire clk,
	input wire sys_rst,
	input wire io_req,
	input wire [`CM_ADDR_W-1:0] io_addr,
	input wire bank_busy,
	input wire blk_want,
	input wire [`CM_ADDR_W-1:0] blk_addr,
	output wire blk_grant,
	output reg req_valid_r,
	output reg [`CM_ADDR_W-1:0] req_addr_r,
	output reg req_is_io_r
);
	reg gap_r;
	// The I/O word always wins; block stream waits two periods at least, longer while the bank is busy
	assign blk_grant = blk_want & ~io_req & ~gap_r & ~bank_busy;
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			gap_r <= 1'b0;
			req_valid_r <= 1'b0;
			req_addr_r <= 18'h00000;
			req_is_io_r <= 1'b0;
		end
		else
		begin
			gap_r <= io_req;
			req_valid_r <= io_req | blk_grant;
			req_is_io_r <= io_req;
			if (io_req)
				req_addr_r <= io_addr;
			else if (blk_grant)
				req_addr_r <= blk_addr;
		end
	end
endmodule

//--- core/ones_add18.v
// 18-bit one's complement adder with end-around carry.
// Assumes purely combinational use in the clk domain.
`timescale 1ns/1ns
module ones_add18
(
	input wire [17:0] a,
	input wire [17:0] b,
	output wire [17:0] sum
);
	wire [18:0] raw;
	wire [18:0] wrap;
	assign raw = {1'b0, a} + {1'b0, b};
	assign wrap = {1'b0, raw[17:0]} + {18'h00000, raw[18]};
	// Minus zero folds to plus zero so a null count is seen as zero
	assign sum = (wrap[17:0] == 18'h3FFFF) ? 18'h00000 : wrap[17:0];
endmodule

//--- shared/blk_copy_regs.vh
// Constants for the block-copy sequencer: field positions, widths, opcodes, register offsets.
// Assumes the includer uses them as plain Verilog macros.
`ifndef BLK_COPY_REGS_VH
`define BLK_COPY_REGS_VH

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define OPC_HI 29
`define OPC_LO 21
`define OPC_W 9
`define OPC_EXT_TO_CM 9'h009
`define OPC_CM_TO_EXT 9'h00A
`define JSEL_HI 20
`define JSEL_LO 18
`define IMM_W 18
`define BLK_W 10
`define EXT_OFS_W 21
`define EXT_BASE_W 22
`define EXT_ADDR_W 22
`define CM_ADDR_W 18
`define WORD_W 60
`define EXIT_CTRL_BIT 86
`define SCW_W 128

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_STATUS 4'h0
`define REG_MASK 4'h1
`define REG_INFO 4'h2
`define ST_DONE 0
`define ST_RANGE 1
`define ST_PASS 2
`define ST_W 3

`endif

//--- tb/ext_mem_model.sv
// Far-side stand-in for the memory banks and the core extension.
// Assumes requests need no handshake; it counts block words and records the first address on each side.
`timescale 1ns/1ns
module ext_mem_model
(
	input wire clk,
	input wire clr,
	input wire mem_v,
	input wire [17:0] mem_a,
	input wire mem_io,
	input wire ext_v,
	input wire [21:0] ext_a,
	output reg bank_busy = 1'b0,
	output reg [10:0] n_mem,
	output reg [10:0] n_ext,
	output reg [17:0] mem0,
	output reg [21:0] ext0
);
always @(posedge clk)
begin
	// Each I/O reference collides with the next block bank
	bank_busy <= mem_v & mem_io;
	if (clr)
	begin
		n_mem <= 11'h000;
		n_ext <= 11'h000;
	end
	else
	begin
		if (mem_v && !mem_io)
			n_mem <= n_mem + 11'h001;
		if (mem_v && !mem_io && n_mem == 11'h000)
			mem0 <= mem_a;
		if (ext_v)
			n_ext <= n_ext + 11'h001;
		if (ext_v && n_ext == 11'h000)
			ext0 <= ext_a;
	end
end
endmodule

//--- tb/ext_memory_block_copy_asserts.sv
// Checker for the block-copy sequencer, bound to its top module.
// Assumes one clock and an active-high reset.
`timescale 1ns/1ns
`include "blk_copy_regs.vh"
module ext_memory_block_copy_asserts
(
	input wire clk,
	input wire sys_rst,
	input wire instr_valid,
	input wire [29:0] instr_word,
	input wire prior_done,
	input wire io_req,
	input wire [17:0] io_addr,
	input wire busy,
	input wire hold_issue,
	input wire halt_other,
	input wire instr_done_r,
	input wire range_err_r,
	input wire cm_req_valid,
	input wire [17:0] cm_req_addr,
	input wire cm_req_is_io,
	input wire cm_req_write,
	input wire ext_req_valid_r,
	input wire [21:0] ext_req_addr_r,
	input wire ext_req_write_r
);
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
sequence take_s;
	instr_valid && !busy && (instr_word[29:21] == `OPC_EXT_TO_CM || instr_word[29:21] == `OPC_CM_TO_EXT);
endsequence
sequence io_word_s;
	cm_req_valid && cm_req_is_io;
endsequence
cmd_start_a: assert property (take_s |=> busy && hold_issue) else $error("issue not held");
drain_wait_a: assert property (busy && !prior_done |-> ##2 !ext_req_valid_r) else $error("early copy");
io_slot_a: assert property (io_req && halt_other |=> io_word_s and (cm_req_addr == $past(io_addr)))
	else $error("io slot lost");
io_gap_a: assert property (io_word_s |=> !(cm_req_valid && !cm_req_is_io)) else $error("no io pause");
ext_seq_a: assert property (ext_req_valid_r && $past(ext_req_valid_r) |-> ext_req_addr_r == $past(ext_req_addr_r) + 22'h1)
	else $error("ext address skip");
dir_write_a: assert property (ext_req_valid_r |-> ext_req_write_r == !cm_req_write) else $error("direction");
range_stop_a: assert property (range_err_r |-> !ext_req_valid_r ##1 !ext_req_valid_r) else $error("moved");
range_done_a: assert property (range_err_r |-> ##[0:4] instr_done_r) else $error("no done");
endmodule
bind ext_memory_block_copy ext_memory_block_copy_asserts i_chk(.clk, .sys_rst, .instr_valid, .instr_word,
	.prior_done, .io_req, .io_addr, .busy, .hold_issue, .halt_other, .instr_done_r, .range_err_r, .cm_req_valid,
	.cm_req_addr, .cm_req_is_io, .cm_req_write, .ext_req_valid_r, .ext_req_addr_r, .ext_req_write_r);

//--- tb/test_ext_memory_block_copy.sv
// Self-checking bench for the block-copy sequencer.
// Assumes the far-side model and the bound checker are compiled with it.
`timescale 1ns/1ns
`include "blk_copy_regs.vh"
module test_ext_memory_block_copy;
reg clk, sys_rst, instr_valid, prior_done, io_req, reg_wr, reg_rd, clr, io_on;
reg [29:0] instr_word;
reg [17:0] count_index_reg;
reg [21:0] ext_field_length;
reg [127:0] system_control_word;
reg [3:0] reg_addr;
reg [31:0] reg_wdata, got;
reg [1:0] ph;
wire [31:0] reg_rdata_r;
wire busy, hold_issue, halt_other, instr_done_r, skip_to_next_word_r, range_err_r, irq, bank_busy;
wire cm_req_valid, cm_req_is_io, cm_req_write, ext_req_valid_r, ext_req_write_r;
wire [17:0] cm_req_addr, mem0;
wire [21:0] ext_req_addr_r, ext0;
wire [10:0] n_mem, n_ext;
integer n_mismatch, checks_done, n;
ext_memory_block_copy i_dut(.clk, .sys_rst, .instr_valid, .instr_word, .prior_done,
	.central_addr_reg(18'h01000), .ext_addr_operand_reg(60'hFFFFFFFFFE00010), .count_index_reg,
	.ext_reference_base(22'h010000), .ext_field_length, .system_control_word, .io_req, .io_addr(18'h0ABCD),
	.peripheral_subsystem_requests(io_on), .bank_busy, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
	.busy, .hold_issue, .halt_other, .instr_done_r, .skip_to_next_word_r, .range_err_r, .cm_req_valid,
	.cm_req_addr, .cm_req_is_io, .cm_req_write, .ext_req_valid_r, .ext_req_addr_r, .ext_req_write_r, .irq);
ext_mem_model i_mem(.clk, .clr, .mem_v(cm_req_valid), .mem_a(cm_req_addr), .mem_io(cm_req_is_io),
	.ext_v(ext_req_valid_r), .ext_a(ext_req_addr_r), .bank_busy, .n_mem, .n_ext, .mem0, .ext0);
initial
begin
	clk = 1'b0;
	forever #50 clk = ~clk;
end
// Sparse I/O words so the bank conflict clears between them
always @(posedge clk)
begin
	ph <= ph + 2'h1;
	io_req <= io_on && ph == 2'h0;
end
task chk(input string nm, input [31:0] e, input [31:0] g);
	checks_done = checks_done + 1;
	if (g !== e)
	begin
		n_mismatch = n_mismatch + 1;
		$display("BAD %s expected %h got %h", nm, e, g);
	end
endtask
task wr(input [3:0] a, input [31:0] d);
	@(posedge clk);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge clk);
	reg_wr <= 1'b0;
endtask
task rd(input [3:0] a);
	@(posedge clk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge clk);
	reg_rd <= 1'b0;
	#1 got = reg_rdata_r;
endtask
task run(input [8:0] op, input [17:0] idx, input [17:0] imm, input [21:0] fl, input xb, input [10:0] w,
	input [2:0] st, input iq);
	@(posedge clk);
	clr <= 1'b1;
	instr_valid <= 1'b1;
	prior_done <= 1'b0;
	instr_word <= {op, 3'h5, imm};
	count_index_reg <= idx;
	ext_field_length <= fl;
	system_control_word[86] <= xb;
	@(posedge clk);
	clr <= 1'b0;
	instr_valid <= 1'b0;
	@(posedge clk);
	prior_done <= 1'b1;
	n = 0;
	while (instr_done_r !== 1'b1 && n < 2000)
	begin
		@(posedge clk);
		#1 n = n + 1;
	end
	chk("done", 1, instr_done_r);
	chk("skip", !xb, skip_to_next_word_r);
	rd(`REG_STATUS);
	chk("status", st, got);
	chk("irq", iq, irq);
	chk("ext words", w, n_ext);
	chk("mem words", w, n_mem);
	if (w != 0)
	begin
		chk("ext start", 22'h010010, ext0);
		chk("mem start", 18'h01000, mem0);
	end
	wr(`REG_STATUS, 32'h7);
	rd(`REG_STATUS);
	chk("cleared", 0, got);
	chk("irq low", 0, irq);
	$display("test op %h count %h ended", op, imm);
endtask
task test_done;
	$display("checks %0d mismatches %0d", checks_done, n_mismatch);
	if (n_mismatch == 0 && checks_done > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
initial
begin
	#(100 * 5000);
	n_mismatch = n_mismatch + 1;
	test_done;
end
initial
begin
	n_mismatch = 0;
	checks_done = 0;
	{sys_rst, instr_valid, prior_done, io_req, reg_wr, reg_rd, clr, io_on, ph} = 10'h200;
	{instr_word, count_index_reg, ext_field_length, reg_addr, reg_wdata, system_control_word} = 0;
	repeat (4) @(posedge clk);
	sys_rst <= 1'b0;
	rd(4'hF);
	chk("unmapped", 0, got);
	rd(`REG_STATUS);
	chk("status reset", 0, got);
	wr(`REG_MASK, 32'h7);
	run(`OPC_EXT_TO_CM, 18'h00003, 18'h00002, 22'h3FFFFF, 1'b0, 11'd5, 3'h1, 1'b1);
	io_on <= 1'b1;
	run(`OPC_CM_TO_EXT, 18'h3FFFE, 18'h00006, 22'h3FFFFF, 1'b1, 11'd5, 3'h1, 1'b1);
	io_on <= 1'b0;
	run(`OPC_EXT_TO_CM, 18'h00000, 18'h00600, 22'h3FFFFF, 1'b0, 11'd512, 3'h1, 1'b1);
	run(`OPC_CM_TO_EXT, 18'h3FFFC, 18'h00003, 22'h3FFFFF, 1'b1, 11'd0, 3'h5, 1'b1);
	wr(`REG_MASK, 32'h4);
	run(`OPC_EXT_TO_CM, 18'h00000, 18'h00401, 22'h000300, 1'b0, 11'd0, 3'h3, 1'b0);
	test_done;
end
endmodule
